// >>> logic/adq_cfg.svh
// Register offsets, field positions, reset values and timing counts of the converter control.
`ifndef ADQ_CFG_SVH
`define ADQ_CFG_SVH
`define ADQ_ADDR_RES_LO 8'h20
`define ADQ_ADDR_RES_HI 8'h21
`define ADQ_ADDR_CTL 8'h22
`define ADQ_ADDR_CSEL 8'h23
`define ADQ_ADDR_ISTS 8'h24
`define ADQ_ADDR_IMSK 8'h25
`define ADQ_CTL_START 7
`define ADQ_CTL_DONE_N 6
`define ADQ_CSEL_TEST 7
`define ADQ_CTL_RESET 8'h40
`define ADQ_CSEL_RESET 8'h80
`define ADQ_SAMPLE_PERIODS 7'h20
`define ADQ_TRIAL_END 7'h44
`define ADQ_LAST_PERIOD 7'h4B
`define ADQ_SEL_DIV2 2'h0
`define ADQ_SEL_DIV8 2'h1
`define ADQ_SEL_DIV32 2'h2
`define ADQ_MASK_DIV2 5'h01
`define ADQ_MASK_DIV8 5'h07
`define ADQ_MASK_DIV32 5'h1F
`endif

// >>> logic/adq_pkg.sv
// Types shared by the converter control modules.
`default_nettype none
package adq_pkg;
  typedef enum logic [2:0] {
    ADQ_IDLE = 3'h1,
    ADQ_HOLD = 3'h2,
    ADQ_RUN = 3'h4
  } adq_state_t;

  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] csel;
    logic [8:0] res;
    logic [8:0] dac;
    logic [6:0] cnt;
    logic ists;
    logic imsk;
    logic [7:0] rd_data;
    adq_state_t st;
  } adq_regs_t;

  typedef struct packed {
    logic [4:0] cnt;
  } adq_div_regs_t;
endpackage
`default_nettype wire

// >>> logic/adq_div_if.sv
// Link between the control core and its conversion clock divider.
`timescale 1ns/1ps
`default_nettype none
interface adq_div_if;
  logic [1:0] sel;
  logic tick;
  modport ctl (output sel, input tick);
  modport div (input sel, output tick);
endinterface
`default_nettype wire

// >>> logic/adq_clkdiv.sv
// Free-running divider that marks one system cycle per conversion clock period.
`timescale 1ns/1ps
`include "adq_cfg.svh"
`default_nettype none
module adq_clkdiv (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  adq_div_if.div dv
);
  adq_pkg::adq_div_regs_t q;
  adq_pkg::adq_div_regs_t next_q;
  logic [4:0] mask;

  // The undefined code runs at the slowest rate so the converter is never overclocked.
  function automatic logic [4:0] div_mask(input logic [1:0] sel);
    case (sel)
      `ADQ_SEL_DIV2: div_mask = `ADQ_MASK_DIV2;
      `ADQ_SEL_DIV8: div_mask = `ADQ_MASK_DIV8;
      default: div_mask = `ADQ_MASK_DIV32;
    endcase
  endfunction

  always_comb begin
    next_q = q;
    next_q.cnt = q.cnt + 5'h01;
    mask = div_mask(dv.sel);
  end

  assign dv.tick = ce && ((q.cnt & mask) == mask);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else if (ce) begin
      q <= next_q;
    end
  end

  property p_div2;
    @(posedge clk) disable iff (!rst_b)
      (dv.tick && dv.sel == `ADQ_SEL_DIV2) ##1 (ce && dv.sel == `ADQ_SEL_DIV2) |-> !dv.tick;
  endproperty
  a_div2: assert property (p_div2) else $error("divide by 2 ticked twice in a row");

  property p_div8;
    @(posedge clk) disable iff (!rst_b)
      (dv.tick && dv.sel == `ADQ_SEL_DIV8) |-> q.cnt[2:0] == 3'h7;
  endproperty
  a_div8: assert property (p_div8) else $error("divide by 8 tick off its phase");
endmodule
`default_nettype wire

// >>> logic/adq_ctrl.sv
// Converter control: registers, start sequencing, approximation, interrupt and port assignment.
// What this block does
// - Result bits 8..1 read in high result register, bit 0 in low register bit 7.
// - Both result registers are read-only; writes leave them unchanged.
// - Start rising resets the converter and sets the done flag; runs once low.
// - Finishing a conversion clears the done flag; zero means conversion ended.
// - Done flag sits at control bit 6, start bit at control bit 7.
// - Each completion sets the interrupt request; delivered only when enabled.
// - Control bits 2..0 select input 0 to 3; codes with bit 2 set unused.
// - Control bits 5..3 give 0,1,2,3 or all four lines to analog use.
// - Analog lines lose digital function and pull-high; converter powers up.
// - Clock select bits 1..0 divide system clock by 2, 8 or 32.
// - Sampling takes 32 conversion clocks, the whole conversion 76.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "adq_cfg.svh"
`default_nettype none
module adq_ctrl (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic irq,
  output logic [1:0] analog_channel,
  output logic [3:0] analog_lines,
  output logic adc_power_on,
  output logic sample_hold,
  output logic [8:0] dac_code,
  input wire logic comp_above
);
  localparam adq_pkg::adq_regs_t RESET_VAL = '{
    ctl: `ADQ_CTL_RESET,
    csel: `ADQ_CSEL_RESET,
    res: 9'h000,
    dac: 9'h000,
    cnt: 7'h00,
    ists: 1'b0,
    imsk: 1'b0,
    rd_data: 8'h00,
    st: adq_pkg::ADQ_IDLE
  };

  adq_pkg::adq_regs_t q;
  adq_pkg::adq_regs_t next_q;
  logic start_rise;
  logic done_evt;
  logic [6:0] off;
  logic [3:0] bitpos;

  adq_div_if dvi ();

  adq_clkdiv u_div (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .dv(dvi.div)
  );

  assign dvi.sel = q.csel[1:0];

  function automatic logic [3:0] line_decode(input logic [2:0] asg);
    case (asg)
      3'h0: line_decode = 4'h0;
      3'h1: line_decode = 4'h1;
      3'h2: line_decode = 4'h3;
      3'h3: line_decode = 4'h7;
      default: line_decode = 4'hF;
    endcase
  endfunction

  function automatic logic [7:0] rd_mux(input logic [7:0] a, input adq_pkg::adq_regs_t r);
    case (a)
      `ADQ_ADDR_RES_LO: rd_mux = {r.res[0], 7'h00};
      `ADQ_ADDR_RES_HI: rd_mux = r.res[8:1];
      `ADQ_ADDR_CTL: rd_mux = r.ctl;
      `ADQ_ADDR_CSEL: rd_mux = {r.csel[`ADQ_CSEL_TEST], 5'h00, r.csel[1:0]};
      `ADQ_ADDR_ISTS: rd_mux = {7'h00, r.ists};
      `ADQ_ADDR_IMSK: rd_mux = {7'h00, r.imsk};
      default: rd_mux = 8'h00;
    endcase
  endfunction

  always_comb begin
    next_q = q;
    next_q.rd_data = 8'h00;
    if (rd_en) begin
      next_q.rd_data = rd_mux(addr, q);
    end
    start_rise = wr_en && (addr == `ADQ_ADDR_CTL) && wr_data[`ADQ_CTL_START]
      && !q.ctl[`ADQ_CTL_START];
    done_evt = (q.st == adq_pkg::ADQ_RUN) && dvi.tick && (q.cnt == `ADQ_LAST_PERIOD);
    off = q.cnt - `ADQ_SAMPLE_PERIODS;
    bitpos = 4'h8 - off[5:2];
    // Result registers have no write path at all.
    if (wr_en) begin
      case (addr)
        `ADQ_ADDR_CTL: begin
          next_q.ctl = {wr_data[7], q.ctl[`ADQ_CTL_DONE_N], wr_data[5:0]};
        end
        `ADQ_ADDR_CSEL: begin
          next_q.csel = {wr_data[7], 5'h00, wr_data[1:0]};
        end
        `ADQ_ADDR_ISTS: begin
          if (wr_data[0]) begin
            next_q.ists = 1'b0;
          end
        end
        `ADQ_ADDR_IMSK: begin
          next_q.imsk = wr_data[0];
        end
        default: begin
        end
      endcase
    end
    case (q.st)
      adq_pkg::ADQ_IDLE: begin
      end
      adq_pkg::ADQ_HOLD: begin
        // The converter stays in reset while start is high.
        if (!q.ctl[`ADQ_CTL_START]) begin
          next_q.st = adq_pkg::ADQ_RUN;
          next_q.cnt = 7'h00;
        end
      end
      adq_pkg::ADQ_RUN: begin
        if (dvi.tick) begin
          next_q.cnt = q.cnt + 7'h01;
          if (q.cnt >= `ADQ_SAMPLE_PERIODS && q.cnt < `ADQ_TRIAL_END) begin
            // Four periods per bit: set the trial, let the comparator settle, decide.
            if (off[1:0] == 2'h0) begin
              next_q.dac[bitpos] = 1'b1;
            end else if (off[1:0] == 2'h3 && !comp_above) begin
              next_q.dac[bitpos] = 1'b0;
            end
          end
        end
      end
      default: begin
        next_q.st = adq_pkg::ADQ_IDLE;
      end
    endcase
    if (done_evt) begin
      next_q.st = adq_pkg::ADQ_IDLE;
      next_q.ctl[`ADQ_CTL_DONE_N] = 1'b0;
      next_q.res = q.dac;
      // Placed after the clear so a completion in the clearing cycle is not lost.
      next_q.ists = 1'b1;
    end
    // A new start edge aborts any conversion and wins over completion for state and done flag; result and status still load.
    if (start_rise) begin
      next_q.st = adq_pkg::ADQ_HOLD;
      next_q.ctl[`ADQ_CTL_DONE_N] = 1'b1;
      next_q.cnt = 7'h00;
      next_q.dac = 9'h000;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= RESET_VAL;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign rd_data = q.rd_data;
  assign irq = q.ists && q.imsk;
  assign analog_channel = q.ctl[1:0];
  assign analog_lines = line_decode(q.ctl[5:3]);
  assign adc_power_on = |q.ctl[5:3];
  assign sample_hold = (q.st == adq_pkg::ADQ_RUN) && (q.cnt < `ADQ_SAMPLE_PERIODS);
  assign dac_code = q.dac;

  property p_res_map;
    @(posedge clk) disable iff (!rst_b)
      ce && rd_en && addr == `ADQ_ADDR_RES_HI |=> rd_data == $past(q.res[8:1]);
  endproperty
  a_res_map: assert property (p_res_map) else $error("high result byte misplaced");

  property p_res_lo;
    @(posedge clk) disable iff (!rst_b)
      ce && rd_en && addr == `ADQ_ADDR_RES_LO |=> rd_data == {$past(q.res[0]), 7'h00};
  endproperty
  a_res_lo: assert property (p_res_lo) else $error("low result byte misplaced");

  property p_res_ro;
    @(posedge clk) disable iff (!rst_b)
      wr_en && (addr == `ADQ_ADDR_RES_LO || addr == `ADQ_ADDR_RES_HI) && !done_evt
      |=> $stable(q.res);
  endproperty
  a_res_ro: assert property (p_res_ro) else $error("result changed by a write");

  sequence s_start;
    ce && start_rise;
  endsequence
  sequence s_reset_state;
    q.ctl[`ADQ_CTL_DONE_N] && q.st == adq_pkg::ADQ_HOLD && q.cnt == 7'h00;
  endsequence
  property p_start;
    @(posedge clk) disable iff (!rst_b) s_start |=> s_reset_state;
  endproperty
  a_start: assert property (p_start) else $error("start edge did not reset converter");

  property p_done;
    @(posedge clk) disable iff (!rst_b)
      ce && done_evt && !start_rise |=> !q.ctl[`ADQ_CTL_DONE_N] && q.ists && irq == q.imsk;
  endproperty
  a_done: assert property (p_done) else $error("completion not flagged");

  property p_ctl_read;
    @(posedge clk) disable iff (!rst_b)
      ce && rd_en && addr == `ADQ_ADDR_CTL
      |=> rd_data[6] == $past(q.ctl[`ADQ_CTL_DONE_N]) && rd_data[7] == $past(q.ctl[7]);
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control bits misplaced");

  property p_lines;
    @(posedge clk) disable iff (!rst_b)
      analog_lines == line_decode(q.ctl[5:3]) && adc_power_on == (analog_lines != 4'h0)
      && analog_channel == q.ctl[1:0];
  endproperty
  a_lines: assert property (p_lines) else $error("line assignment wrong");

  property p_csel_read;
    @(posedge clk) disable iff (!rst_b)
      ce && rd_en && addr == `ADQ_ADDR_CSEL |=> rd_data[6:2] == 5'h00;
  endproperty
  a_csel_read: assert property (p_csel_read) else $error("clock select unused bits set");

  property p_sample;
    @(posedge clk) disable iff (!rst_b)
      q.st == adq_pkg::ADQ_RUN && q.cnt == 7'h1F && dvi.tick |=> !sample_hold;
  endproperty
  a_sample: assert property (p_sample) else $error("sampling exceeded 32 periods");

  property p_irq_set;
    @(posedge clk) disable iff (!rst_b)
      ce && done_evt && q.imsk && !(wr_en && addr == `ADQ_ADDR_IMSK) |=> irq;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("enabled completion gave no interrupt");

  // Clearing status must only drop the bit when no completion lands in the same cycle.
  property p_ists_w1c;
    @(posedge clk) disable iff (!rst_b)
      ce && wr_en && addr == `ADQ_ADDR_ISTS && wr_data[0] && !done_evt |=> !q.ists;
  endproperty
  a_ists_w1c: assert property (p_ists_w1c) else $error("status bit not cleared");

  // An interrupt is delivered only while it is enabled.
  property p_irq_gate;
    @(posedge clk) disable iff (!rst_b)
      !q.imsk |-> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("masked interrupt raised");

  property p_done_hold;
    @(posedge clk) disable iff (!rst_b)
      ce && !q.ctl[`ADQ_CTL_DONE_N] && !start_rise |=> !q.ctl[`ADQ_CTL_DONE_N];
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done flag rose unasked");

  // While start stays high the converter must sit in reset with an empty count.
  property p_hold_reset;
    @(posedge clk) disable iff (!rst_b)
      ce && q.st == adq_pkg::ADQ_HOLD && q.ctl[`ADQ_CTL_START]
      && !(wr_en && addr == `ADQ_ADDR_CTL)
      |=> q.st == adq_pkg::ADQ_HOLD && q.cnt == 7'h00 && !sample_hold;
  endproperty
  a_hold_reset: assert property (p_hold_reset) else $error("left reset early");

  sequence s_running;
    q.st == adq_pkg::ADQ_RUN;
  endsequence
  sequence s_cleared;
    q.st == adq_pkg::ADQ_HOLD && dac_code == 9'h000 && !sample_hold;
  endsequence
  property p_abort;
    @(posedge clk) disable iff (!rst_b) s_running ##0 s_start |=> s_cleared;
  endproperty
  a_abort: assert property (p_abort) else $error("restart did not abort the run");

  // The first trial after sampling must raise the top bit of the trial code.
  sequence s_first_trial;
    ce && q.st == adq_pkg::ADQ_RUN && dvi.tick
    && q.cnt == `ADQ_SAMPLE_PERIODS && !start_rise;
  endsequence
  property p_trial;
    @(posedge clk) disable iff (!rst_b) s_first_trial |=> dac_code[8] && !sample_hold;
  endproperty
  a_trial: assert property (p_trial) else $error("first trial bit not set");

  property p_csel_wr;
    @(posedge clk) disable iff (!rst_b)
      ce && wr_en && addr == `ADQ_ADDR_CSEL |=> dvi.sel == $past(wr_data[1:0]);
  endproperty
  a_csel_wr: assert property (p_csel_wr) else $error("divide code not taken");
endmodule
`default_nettype wire

// >>> dv/adq_comp_model.sv
// Comparator and analog source model that answers the approximation trials.
`timescale 1ns/1ps
`default_nettype none
module adq_comp_model (
  input wire logic [1:0] analog_channel,
  input wire logic [3:0] analog_lines,
  input wire logic [8:0] dac_code,
  input wire logic [3:0][8:0] level,
  output logic comp_above
);
  // A line left digital is cut off from the converter, so it reads as ground.
  always_comb begin
    comp_above = analog_lines[analog_channel] && (level[analog_channel] >= dac_code);
  end
endmodule
`default_nettype wire

// >>> dv/adc_sequencer_control_tb.sv
// Randomised self-checking bench for the converter control.
`timescale 1ns/1ps
`include "adq_cfg.svh"
`default_nettype none
module adc_sequencer_control_tb;
  logic clk, rst_b, ce, wr_en, rd_en, comp_above, irq, adc_power_on, sample_hold;
  logic [7:0] addr, wr_data, rd_data, v;
  logic [1:0] analog_channel, ch;
  logic [3:0] analog_lines;
  logic [2:0] asg;
  logic [8:0] dac_code;
  logic [3:0][8:0] lvl;
  int fail_count, num_checks, sh;
  adq_ctrl DUT (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq),
    .analog_channel(analog_channel), .analog_lines(analog_lines),
    .adc_power_on(adc_power_on), .sample_hold(sample_hold), .dac_code(dac_code),
    .comp_above(comp_above));
  adq_comp_model CMP (.analog_channel(analog_channel), .analog_lines(analog_lines),
    .dac_code(dac_code), .level(lvl), .comp_above(comp_above));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (sample_hold === 1'b1) sh <= sh + 1;
  end
  function automatic logic [3:0] lines_of(input logic [2:0] g);
    return g[2] ? 4'hF : 4'(4'hF >> (3'h4 - {1'b0, g[1:0]}));
  endfunction
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk({1'b0, rd_data}, {1'b0, e});
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic conv(input logic [1:0] s, input logic [2:0] g, input logic [1:0] c,
    input int ab);
    int n;
    int d;
    logic [7:0] b;
    logic [3:0] lm;
    logic [8:0] r;
    d = 2 << (2 * s);
    b = {2'h0, g, 1'b0, c};
    lm = lines_of(g);
    r = lm[c] ? lvl[c] : 9'h000;
    wr(`ADQ_ADDR_CSEL, {6'h00, s});
    for (int i = 0; i <= ab; i++) begin
      // The second pass restarts in mid-sampling to show the abort.
      if (i > 0) repeat (40) @(posedge clk);
      wr(`ADQ_ADDR_CTL, b | 8'h80);
      rdc(`ADQ_ADDR_CTL, b | 8'hC0);
      wr(`ADQ_ADDR_CTL, b);
    end
    sh = 0;
    chk(9'(analog_lines), 9'(lm));
    chk(9'(analog_channel), 9'(c));
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(9'(n >= 75 * d && n <= 77 * d + 4), 9'h001);
    chk(9'(sh >= 31 * d && sh <= 33 * d + 2), 9'h001);
    rdc(`ADQ_ADDR_CTL, b);
    rdc(`ADQ_ADDR_RES_HI, r[8:1]);
    rdc(`ADQ_ADDR_RES_LO, {r[0], 7'h00});
    rdc(`ADQ_ADDR_ISTS, 8'h01);
    wr(`ADQ_ADDR_ISTS, 8'h01);
    @(posedge clk);
    #1;
    chk(9'(irq), 9'h000);
  endtask
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    rst_b = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    ce = 1'b1;
    lvl = '0;
    fail_count = 0;
    num_checks = 0;
    sh = 0;
    v = 8'($urandom(65));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk(9'({irq, adc_power_on, analog_lines}), 9'h000);
    rdc(`ADQ_ADDR_CTL, 8'h40);
    rdc(`ADQ_ADDR_CSEL, 8'h80);
    rdc(8'h30, 8'h00);
    // A start write made while the enable is low must leave no trace.
    @(posedge clk);
    ce <= 1'b0;
    wr(`ADQ_ADDR_CTL, 8'h88);
    ce <= 1'b1;
    #1;
    chk(9'(analog_lines), 9'h000);
    rdc(`ADQ_ADDR_CTL, 8'h40);
    wr(`ADQ_ADDR_CSEL, 8'h7C);
    rdc(`ADQ_ADDR_CSEL, 8'h00);
    wr(`ADQ_ADDR_RES_LO, 8'hFF);
    wr(`ADQ_ADDR_RES_HI, v);
    rdc(`ADQ_ADDR_RES_LO, 8'h00);
    rdc(`ADQ_ADDR_RES_HI, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(`ADQ_ADDR_CTL, {2'h2, 3'(k), 3'h0});
      wr(`ADQ_ADDR_CTL, {2'h0, 3'(k), 3'h0});
      chk(9'(analog_lines), 9'(lines_of(3'(k))));
      chk(9'(adc_power_on), 9'(k != 0));
    end
    wr(`ADQ_ADDR_CTL, 8'hA0);
    wr(`ADQ_ADDR_CTL, 8'h20);
    repeat (200) @(posedge clk);
    chk(9'(irq), 9'h000);
    rdc(`ADQ_ADDR_ISTS, 8'h01);
    wr(`ADQ_ADDR_IMSK, 8'h01);
    @(posedge clk);
    #1;
    chk(9'(irq), 9'h001);
    wr(`ADQ_ADDR_ISTS, 8'h01);
    for (int s = 0; s < 3; s++) begin
      for (int k = 0; k < 3; k++) begin
        lvl = 36'({$urandom(), $urandom()});
        ch = 2'($urandom_range(3, 0));
        asg = 3'($urandom_range(7, 0));
        if (k == 0) lvl[ch] = 9'h1FF;
        if (k == 1) lvl[ch] = 9'h000;
        conv(2'(s), asg, ch, int'(k == 2));
      end
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
